// *** hdl/lss_defines.svh ***
`ifndef LSS_DEFINES_SVH
`define LSS_DEFINES_SVH

// System clock and sensor clock limit
`define LSS_MCLK_HZ        25000000
`define LSS_PIX_MAX_HZ     10000000
// Even divider so the sensor clock has 50 percent duty and stays under the limit
`define LSS_DIV            (((`LSS_MCLK_HZ + 2 * `LSS_PIX_MAX_HZ - 1) / (2 * `LSS_PIX_MAX_HZ)) * 2)
`define LSS_HALF           (`LSS_DIV / 2)

// Scan timing, in sensor clock periods
`define LSS_INT_EXTRA      48
`define LSS_GATE_SPACE_MIN 106
`define LSS_GATE_HIGH_MIN  6
`define LSS_GATE_LOW_MIN   100
`define LSS_PERIOD_MIN     4188
`define LSS_FIRST_STROBE   89
`define LSS_PIXELS         4096
`define LSS_EFFECTIVE      4008
`define LSS_BLACK          20
`define LSS_LAST_STROBE    (`LSS_FIRST_STROBE + `LSS_PIXELS - 1)

// Reset values
`define LSS_VIDEO_RST      16'h0000
`define LSS_PERIOD_RST     16'h105c
`define LSS_HIGH_RST       16'h0006

`endif

// *** hdl/lss_pkg.sv ***
package lss_pkg;
  `include "lss_defines.svh"

  typedef logic [15:0] lss_video_t;
  typedef logic [12:0] lss_cnt_t;
  typedef logic [11:0] lss_index_t;
  typedef logic [15:0] lss_time_t;

  typedef enum logic [0:0] {
    LSS_IDLE,
    LSS_READ
  } lss_state_t;
endpackage

// *** hdl/lss_link_if.sv ***
`timescale 1ns/1ps
interface lss_link_if;
  import lss_pkg::*;
  logic       sclk;
  logic       integration_gate;
  lss_video_t video;
  logic       strobe;

  modport dev (
    input  sclk,
    input  integration_gate,
    output video,
    output strobe
  );
  modport ctl (
    output sclk,
    output integration_gate,
    input  video,
    input  strobe
  );
endinterface

// *** hdl/lss_sensor.sv ***
`timescale 1ns/1ps
`include "lss_defines.svh"
module lss_sensor
  import lss_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  lss_link_if.dev     link,
  input  wire logic [7:0] light,
  output logic        integrating,
  output lss_video_t  exposure,
  output logic        line_active
);

  localparam int FIRST = `LSS_FIRST_STROBE;
  localparam int LAST  = `LSS_LAST_STROBE;
  localparam int BLACK = `LSS_BLACK;
  localparam int EFF   = `LSS_EFFECTIVE;
  localparam int EXTRA = `LSS_INT_EXTRA;

  logic       sclk_q;
  logic       gate_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       gate_fell;
  logic [5:0] ext_cnt;
  lss_video_t acc;
  lss_video_t acc_sum;
  lss_state_t state;
  lss_cnt_t   cnt;
  lss_cnt_t   next_cnt;

  // Pixel number in the line is an effective (not shielded) pixel
  function automatic logic is_effective(input lss_cnt_t strobe_no);
    return (strobe_no >= 13'(FIRST + BLACK)) && (strobe_no < 13'(FIRST + BLACK + EFF));
  endfunction

  // Sensor clock edges seen in the system clock
  assign sclk_rise = link.sclk & ~sclk_q;
  assign sclk_fall = ~link.sclk & sclk_q;
  assign gate_fell = sclk_rise & gate_q & ~link.integration_gate;
  assign next_cnt  = cnt + 13'd1;

  // Saturating sum including light of the current sensor clock
  assign acc_sum = (acc > 16'hffff - {8'h00, light}) ? 16'hffff : acc + {8'h00, light};

  // Edge history
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
      if (sclk_rise) begin
        gate_q <= link.integration_gate;
      end
    end
  end

  // Global shutter: all pixels integrate together, gate high plus 48 clocks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      integrating <= 1'b0;
      ext_cnt     <= 6'd0;
      acc         <= `LSS_VIDEO_RST;
      exposure    <= `LSS_VIDEO_RST;
    end else if (sclk_rise) begin
      if (link.integration_gate && !gate_q) begin
        integrating <= 1'b1;
        acc         <= `LSS_VIDEO_RST;
        ext_cnt     <= 6'd0;
      end else if (integrating) begin
        acc <= acc_sum;
        if (!link.integration_gate) begin
          if (ext_cnt == 6'(EXTRA)) begin
            integrating <= 1'b0;
            exposure    <= acc_sum;
          end
          ext_cnt <= ext_cnt + 6'd1;
        end
      end
    end
  end

  // Readout shift register, one pixel per sensor clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state      <= LSS_IDLE;
      cnt        <= '0;
      link.video <= `LSS_VIDEO_RST;
    end else if (sclk_rise) begin
      if (gate_fell) begin
        state      <= LSS_READ;
        cnt        <= 13'd1;
        link.video <= `LSS_VIDEO_RST;
      end else begin
        case (state)
          LSS_IDLE: begin
            cnt <= '0;
          end
          LSS_READ: begin
            if (cnt == 13'(LAST)) begin
              state <= LSS_IDLE;
            end else begin
              cnt <= next_cnt;
              // Shielded pixels read dark
              link.video <= is_effective(next_cnt) ? exposure : `LSS_VIDEO_RST;
            end
          end
          default: begin
            state <= LSS_IDLE;
          end
        endcase
      end
    end
  end

  // Strobe rises mid pixel, while video is steady
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.strobe <= 1'b0;
    end else if (sclk_rise) begin
      link.strobe <= 1'b0;
    end else if (sclk_fall) begin
      link.strobe <= (state == LSS_READ);
    end
  end

  assign line_active = (state == LSS_READ);

endmodule

// *** hdl/lss_controller.sv ***
// Notes on behaviour
// - Integration equals gate high plus 48 clocks
// - Readout starts first clock after gate falls
// - Gate pulses at least 106 clocks apart
// - Gate high at least 6 clocks
// - Gate low at least 100 clocks
// - One pixel per clock, clock under 10 MHz
// - Sample video on strobe rising edge
// - First strobe counts one, pixel at 89th
// - 4096 pixels, 4008 effective, 20 black each end; code reads 20 dark at the start, 68 dark at the end
// - All pixels integrate simultaneously
// - Integration set by gate high period
// - Gate and clock always driven defined
// - Discard the first scan after power-on
// - Gate period at least 4188 clocks
`timescale 1ns/1ps
`include "lss_defines.svh"
module lss_controller
  import lss_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  input  wire logic   run,
  input  lss_time_t   cfg_period,
  input  lss_time_t   cfg_high,
  lss_link_if.ctl     link,
  output lss_video_t  pix_data,
  output lss_index_t  pix_index,
  output logic        pix_valid,
  output logic        line_done,
  output logic        scan_valid,
  output logic        busy
);

  localparam int DIV   = `LSS_DIV;
  localparam int HALF  = `LSS_HALF;
  localparam int FIRST = `LSS_FIRST_STROBE;
  localparam int LAST  = `LSS_LAST_STROBE;

  logic [1:0] ph;
  logic       rise_en;
  logic       fall_en;
  lss_time_t  gcnt;
  lss_time_t  period;
  lss_time_t  high;
  lss_time_t  next_period;
  lss_time_t  next_high;
  logic       strobe_q;
  logic       strobe_rise;
  lss_cnt_t   scnt;
  lss_cnt_t   next_scnt;
  logic       seen_scan;
  logic       counting;
  logic       period_end;
  logic       scan_start;
  logic       gate_drop;

  // Clamp requested period to the readout minimum
  function automatic lss_time_t clamp_period(input lss_time_t req);
    lss_time_t p;
    p = req;
    if (p < 16'(`LSS_PERIOD_MIN)) begin
      p = 16'(`LSS_PERIOD_MIN);
    end
    if (p < 16'(`LSS_GATE_SPACE_MIN)) begin
      p = 16'(`LSS_GATE_SPACE_MIN);
    end
    return p;
  endfunction

  // Clamp gate high so both high and low minimums hold
  function automatic lss_time_t clamp_high(input lss_time_t req, input lss_time_t p);
    lss_time_t h;
    h = req;
    if (h < 16'(`LSS_GATE_HIGH_MIN)) begin
      h = 16'(`LSS_GATE_HIGH_MIN);
    end
    if (h > p - 16'(`LSS_GATE_LOW_MIN)) begin
      h = p - 16'(`LSS_GATE_LOW_MIN);
    end
    return h;
  endfunction

  assign next_period = clamp_period(cfg_period);
  assign next_high   = clamp_high(cfg_high, next_period);

  // Sensor clock divider, even ratio keeps the rate under the limit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ph        <= 2'd0;
      link.sclk <= 1'b0;
    end else begin
      ph <= (ph == 2'(DIV - 1)) ? 2'd0 : ph + 2'd1;
      if (ph == 2'(DIV - 1)) begin
        link.sclk <= 1'b1;
      end else if (ph == 2'(HALF - 1)) begin
        link.sclk <= 1'b0;
      end
    end
  end

  // One-cycle enables at the edges the sensor will see
  assign rise_en = (ph == 2'(DIV - 1));
  assign fall_en = (ph == 2'(HALF - 1));

  // Period boundary, scan start and gate drop, all on sensor clock falling edges
  assign period_end = fall_en && busy && (gcnt == period);
  assign scan_start = fall_en && run && (!busy || period_end);
  assign gate_drop  = fall_en && busy && link.integration_gate && (gcnt == high);

  // Settings take effect at a period boundary only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      period <= `LSS_PERIOD_RST;
      high   <= `LSS_HIGH_RST;
    end else if (scan_start) begin
      period <= next_period;
      high   <= next_high;
    end
  end

  // Sequencing active from a start until a period ends with run low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (scan_start) begin
      busy <= 1'b1;
    end else if (period_end) begin
      busy <= 1'b0;
    end
  end

  // Gate period counter, counts 1 to period in sensor clocks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gcnt <= 16'h0000;
    end else if (scan_start) begin
      gcnt <= 16'h0001;
    end else if (period_end) begin
      gcnt <= 16'h0000;
    end else if (fall_en && busy) begin
      gcnt <= gcnt + 16'h0001;
    end
  end

  // Gate level, moves on sensor clock falling edges only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.integration_gate <= 1'b0;
    end else if (scan_start) begin
      link.integration_gate <= 1'b1;
    end else if (gate_drop) begin
      link.integration_gate <= 1'b0;
    end
  end

  // Strobe edge detection
  assign strobe_rise = link.strobe & ~strobe_q;
  assign next_scnt   = scnt + 13'd1;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= link.strobe;
    end
  end

  // Strobe count restarts at each gate fall; first scan is discarded
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scnt       <= '0;
      counting   <= 1'b0;
      seen_scan  <= 1'b0;
      scan_valid <= 1'b0;
    end else if (gate_drop) begin
      // Strobe numbering restarts with the gate fall
      scnt       <= '0;
      counting   <= 1'b1;
      scan_valid <= seen_scan;
      seen_scan  <= 1'b1;
    end else if (strobe_rise && counting) begin
      scnt <= next_scnt;
      if (scnt == 13'(LAST - 1)) begin
        counting <= 1'b0;
      end
    end
  end

  // Pixel capture on strobe rising edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pix_data  <= `LSS_VIDEO_RST;
      pix_index <= '0;
      pix_valid <= 1'b0;
      line_done <= 1'b0;
    end else begin
      pix_valid <= 1'b0;
      line_done <= 1'b0;
      if (strobe_rise && counting && next_scnt >= 13'(FIRST)) begin
        pix_data  <= link.video;
        pix_index <= 12'(next_scnt - 13'(FIRST));
        pix_valid <= scan_valid;
        line_done <= (next_scnt == 13'(LAST)) & scan_valid;
      end
    end
  end

endmodule

// *** testbench/lss_link_props.sv ***
`timescale 1ns/1ps
module lss_link_props
  import lss_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       sclk,
  input wire logic       integration_gate,
  input wire lss_video_t video,
  input wire logic       strobe
);
  logic        gq;
  logic        armed;
  logic [15:0] run_len;
  logic [15:0] per_len;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Gate level run length and rise-to-rise period in mclk
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gq <= 1'b0;
      armed <= 1'b0;
      run_len <= 16'h0000;
      per_len <= 16'h0000;
    end else begin
      gq <= integration_gate;
      run_len <= (integration_gate != gq) ? 16'h0001 : run_len + 16'h0001;
      per_len <= (integration_gate && !gq) ? 16'h0001 : per_len + 16'h0001;
      if (integration_gate && !gq) begin
        armed <= 1'b1;
      end
    end
  end
  a_sclk_half_min: assert property ($changed(sclk) |=> $stable(sclk))
    else $error("sclk half period short");
  a_sclk_rate_max: assert property ($rose(sclk) |=> sclk ##1 !sclk ##1 !sclk)
    else $error("sclk faster than pixel limit");
  a_gate_high_min: assert property (!integration_gate && gq |-> run_len >= 16'h0018)
    else $error("gate high too short");
  a_gate_low_min: assert property (armed && integration_gate && !gq |-> run_len >= 16'h0190)
    else $error("gate low too short");
  a_gate_period_min: assert property (armed && integration_gate && !gq |-> per_len >= 16'h4170)
    else $error("gate period too short");
  a_strobe_shape: assert property ($rose(strobe) |=> strobe ##1 !strobe ##1 !strobe)
    else $error("strobe shape wrong");
  a_video_at_strobe: assert property (strobe |-> $stable(video))
    else $error("video moved under strobe");
  a_strobe_after_fall: assert property ($fell(integration_gate) |-> ##[1:12] $rose(strobe))
    else $error("no strobe after gate fall");
  a_gate_off_rise: assert property ($changed(integration_gate) |-> !$rose(sclk))
    else $error("gate moved at sclk rise");
endmodule

// *** testbench/linear_sensor_scan_sequencer_bench.sv ***
`timescale 1ns/1ps
module linear_sensor_scan_sequencer_bench
  import lss_pkg::*;
;
  logic       mclk;
  logic       rst_n = 1'b0;
  logic       run = 1'b0;
  lss_time_t  cfg_period = 16'h0000;
  lss_time_t  cfg_high = 16'h0002;
  logic [7:0] light = 8'h03;
  logic       integrating;
  lss_video_t exposure;
  logic       line_active;
  lss_video_t pix_data;
  lss_index_t pix_index;
  logic       pix_valid;
  logic       line_done;
  logic       scan_valid;
  logic       busy;
  logic       gq = 1'b0;
  logic       iq = 1'b0;
  logic       sq = 1'b0;
  lss_video_t vid;
  int         failures = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         hi_len = 0;
  int         per_len = 0;
  int         in_len = 0;
  int         scnt = 0;
  int         npix = 0;
  int         nfall = 0;
  int         ndone = 0;

  lss_link_if link_i ();
  lss_sensor lss_sensor_inst (.mclk(mclk), .rst_n(rst_n), .link(link_i), .light(light),
    .integrating(integrating), .exposure(exposure), .line_active(line_active));
  lss_controller lss_controller_inst (.mclk(mclk), .rst_n(rst_n), .run(run), .cfg_period(cfg_period),
    .cfg_high(cfg_high), .link(link_i), .pix_data(pix_data), .pix_index(pix_index), .pix_valid(pix_valid),
    .line_done(line_done), .scan_valid(scan_valid), .busy(busy));
  lss_link_props props_i (.mclk(mclk), .rst_n(rst_n), .sclk(link_i.sclk),
    .integration_gate(link_i.integration_gate), .video(link_i.video), .strobe(link_i.strobe));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 70000) begin
      failures++;
      close_out();
    end
  end

  // Link and user side monitor, on the settled half
  always @(negedge mclk) begin
    if (rst_n) begin
      if (link_i.strobe && !sq) begin
        scnt++;
        vid = link_i.video;
      end
      if (pix_valid) begin
        check({4'h0, pix_index}, 16'(scnt - 89));
        check(pix_data, vid);
        check({15'h0, scan_valid}, 16'h0001);
        if (pix_index < 20 || pix_index >= 4028) begin
          check(pix_data, 16'h0000);
        end else begin
          check(pix_data, 16'h00a2);
        end
        npix++;
      end
      if (line_done) begin
        check({4'h0, pix_index}, 16'h0fff);
        ndone++;
      end
      if (link_i.strobe) begin
        check({15'h0, line_active}, 16'h0001);
      end
      if (link_i.integration_gate) begin
        hi_len++;
      end else if (gq) begin
        check(16'(hi_len), 16'h0018);
        hi_len = 0;
        scnt = 0;
        nfall++;
      end
      if (link_i.integration_gate && !gq && per_len != 0) check(16'(per_len), 16'h4170);
      per_len = (link_i.integration_gate && !gq) ? 1 : (per_len != 0 ? per_len + 1 : 0);
      if (integrating) begin
        in_len++;
      end else if (iq) begin
        check(16'(in_len), 16'h00d8);
        in_len = 0;
      end
      gq = link_i.integration_gate;
      iq = integrating;
      sq = link_i.strobe;
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    run = 1'b1;
    @(posedge mclk iff nfall == 3);
    #1 run = 1'b0;
    @(posedge mclk iff busy === 1'b0);
    repeat (100) @(posedge mclk);
    check(16'(npix), 16'h2000);
    check(16'(scnt), 16'h1058);
    check(16'(nfall), 16'h0003);
    check(16'(ndone), 16'h0002);
    check(exposure, 16'h00a2);
    check({15'h0, line_active}, 16'h0000);
    check({15'h0, link_i.integration_gate}, 16'h0000);
    close_out();
  end
endmodule
